// ===== logic/acsp_pkg.sv
// Constants, field layout and timing counts for the converter serial port.
// Assumes a single 100 MHz ref_clk on both ends.
// Notes on behaviour
// - spanning access reads n-1, config governs n+1
// - host stops all clocking before safe-access time
// - at full rate access fits acquisition plus safe
// - slow rate: any clock speed, acquisition first
// - no access while conversion start is high
// - host splits spanning access into two bursts
// - 14-bit word shifted in MSB first, rising edges
// - capture depends on serial clock edges only
// - writes accepted in conversion, acquisition, both
// - new word takes effect at conversion end
// - one-deep delay between write and use
// - host runs two dummy conversions after power-up
// - data-in high two conversions loads all ones
// - all-ones selects scan of eight inputs, defaults
// - word fields at fixed bit positions
// - update bit zero discards word, one overwrites
// - three-bit field selects input arrangement
package acsp_pkg;
    localparam int CLK_MHZ = 100;
    localparam int CFG_W = 14;
    localparam int RESULT_W = 16;
    localparam int OUT_W = 30;

    localparam int UPD_BIT = 13;
    localparam int ARR_HI = 12;
    localparam int ARR_LO = 10;
    localparam int CH_HI = 9;
    localparam int CH_LO = 7;
    localparam int FILT_BIT = 6;
    localparam int REF_HI = 5;
    localparam int REF_LO = 3;
    localparam int SCAN_HI = 2;
    localparam int SCAN_LO = 1;
    localparam int ECHO_BIT = 0;

    localparam logic [13:0] CFG_DEFAULT = 14'h3fff;
    localparam logic [13:0] CFG_RESET = 14'h0000;
    localparam logic [2:0] LAST_CHANNEL = 3'h7;

    localparam int CONV_TIME_NS = 1600;
    localparam int DATA_TIME_NS = 1200;
    localparam int GO_HIGH_NS = 100;
    localparam int SCLK_HALF_NS = 80;
    localparam logic [7:0] CONV_CYC = 8'((CONV_TIME_NS * CLK_MHZ) / 1000);
    localparam logic [7:0] DATA_CYC = 8'((DATA_TIME_NS * CLK_MHZ) / 1000);
    localparam logic [7:0] GO_HIGH_CYC = 8'((GO_HIGH_NS * CLK_MHZ + 999) / 1000);
    localparam logic [3:0] SCLK_HALF_CYC = 4'((SCLK_HALF_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] SYNC_MARGIN = 8'h04;

    localparam logic [1:0] PRIME_CONVS = 2'h2;
    localparam logic [1:0] DEFAULT_RUN = 2'h2;
    localparam logic [4:0] CFG_EDGES = 5'h0e;
    localparam logic [4:0] EDGES_PLAIN = 5'h10;
    localparam logic [4:0] EDGES_ECHO = 5'h1e;
    localparam logic [4:0] BURST2_EDGES = 5'h06;

    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_CFGW = 12'h004;
    localparam logic [11:0] OFS_STAT = 12'h008;
    localparam logic [11:0] OFS_RESULT = 12'h00c;
    localparam logic [11:0] OFS_ECHO = 12'h010;
    localparam int CTRL_START = 0;
    localparam int CTRL_ECHO = 1;
    localparam int CTRL_PRELOAD = 2;
endpackage

// ===== logic/acsp_if.sv
// Four-wire link between converter and host controller.
// No clock inside: both ends sample their incoming pins on their own ref_clk.
`timescale 1ns/1ps
interface acsp_if;
    logic conversionStart;
    logic serialClock;
    logic dataIn;
    logic dataOut;
    modport device (
        input conversionStart,
        input serialClock,
        input dataIn,
        output dataOut
    );
    modport host (
        output conversionStart,
        output serialClock,
        output dataIn,
        input dataOut
    );
endinterface

// ===== logic/acsp_edge_sync.sv
// Two-stage synchroniser with edge detection for one link pin.
// Assumes the pin is asynchronous to ref_clk.
`timescale 1ns/1ps
module acsp_edge_sync (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic pinIn,
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta_q;
    logic level_q;
    logic prev_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meta_q <= 1'b0;
            level_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= pinIn;
            level_q <= meta_q;
            prev_q <= level_q;
        end
    end

    assign level = level_q;
    assign rise = level_q & ~prev_q;
    assign fall = ~level_q & prev_q;
endmodule

// ===== logic/acsp_device.sv
// Converter end of the serial port: configuration capture, staging,
// conversion timing, channel scan and serial result output.
// Assumes the host keeps its own timing; the analog result is modelled
// by the converted channel and a running sample count.
`timescale 1ns/1ps
module acsp_device (
    input wire logic ref_clk,
    input wire logic rst,
    acsp_if.device link,
    output logic [13:0] activeConfig,
    output logic configValid,
    output logic convBusy,
    output logic convDone,
    output logic [2:0] convChannel,
    output logic [2:0] inputArrangement,
    output logic filterBandwidth,
    output logic [2:0] referenceSelect,
    output logic [1:0] scanControl,
    output logic configEcho
);
    logic goLevel;
    logic goRise;
    logic sclkRise;
    logic sclkFall;
    logic dinLevel;

    acsp_edge_sync goSync (
        .ref_clk(ref_clk),
        .rst(rst),
        .pinIn(link.conversionStart),
        .level(goLevel),
        .rise(goRise),
        .fall()
    );

    acsp_edge_sync sclkSync (
        .ref_clk(ref_clk),
        .rst(rst),
        .pinIn(link.serialClock),
        .level(),
        .rise(sclkRise),
        .fall(sclkFall)
    );

    acsp_edge_sync dinSync (
        .ref_clk(ref_clk),
        .rst(rst),
        .pinIn(link.dataIn),
        .level(dinLevel),
        .rise(),
        .fall()
    );

    logic convBusy_q;
    logic [7:0] convCnt_q;
    logic convDone_q;
    logic [13:0] active_q;
    logic [13:0] convCfg_q;
    logic [13:0] inShift_q;
    logic [4:0] inCnt_q;
    logic [13:0] pending_q;
    logic pendingValid_q;
    logic dinSawLow_q;
    logic [1:0] highRun_q;
    logic [1:0] primeCnt_q;
    logic [2:0] scanChan_q;
    logic [2:0] chan_q;
    logic [12:0] sampleCnt_q;
    logic [29:0] outShift_q;

    // a conversion starts on the rising edge of the start line
    wire convStart = goRise & ~convBusy_q;
    wire convEnd = convBusy_q && (convCnt_q == acsp_pkg::CONV_CYC - 8'h01);

    // the serial port is deselected while the start line is high
    wire portOpen = ~goLevel;
    wire takeBit = sclkRise & portOpen & (inCnt_q < acsp_pkg::CFG_EDGES);
    wire [13:0] shiftedWord = {inShift_q[12:0], dinLevel};
    wire wordDone = takeBit && (inCnt_q == acsp_pkg::CFG_EDGES - 5'h01);

    // a word is only applied when its update bit asks for it
    wire applyWord = pendingValid_q & pending_q[acsp_pkg::UPD_BIT];
    wire dinHighPeriod = ~dinSawLow_q & dinLevel;
    wire applyDefault = dinHighPeriod && (highRun_q == acsp_pkg::DEFAULT_RUN - 2'h1);
    wire [13:0] nextActive = applyWord ? pending_q :
                             applyDefault ? acsp_pkg::CFG_DEFAULT : active_q;
    wire cfgChanged = applyWord | applyDefault;

    wire scanOn = active_q[acsp_pkg::SCAN_HI:acsp_pkg::SCAN_LO] != 2'h0;
    wire [2:0] lastChan = active_q[acsp_pkg::CH_HI:acsp_pkg::CH_LO];
    wire [2:0] useChan = scanOn ? scanChan_q : lastChan;
    wire [2:0] scanNext = (scanChan_q >= lastChan) ? 3'h0 : scanChan_q + 3'h1;
    // readback of the configuration is off when its bit is one
    wire echoOn = ~convCfg_q[acsp_pkg::ECHO_BIT];
    wire [13:0] echoWord = echoOn ? convCfg_q : 14'h0000;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            convBusy_q <= 1'b0;
            convCnt_q <= 8'h00;
            convDone_q <= 1'b0;
        end else begin
            convDone_q <= convEnd;
            if (convStart) begin
                convBusy_q <= 1'b1;
                convCnt_q <= 8'h00;
            end else if (convEnd) begin
                convBusy_q <= 1'b0;
            end else if (convBusy_q) begin
                convCnt_q <= convCnt_q + 8'h01;
            end
        end
    end

    // capture is paced by serial clock edges alone, so any host rate works whose clock phases each outlast a ref_clk cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            inShift_q <= 14'h0000;
            inCnt_q <= 5'h00;
            pending_q <= acsp_pkg::CFG_RESET;
            pendingValid_q <= 1'b0;
        end else if (convEnd) begin
            // a partial word is dropped here; an edge in this cycle is lost
            inCnt_q <= 5'h00;
            pendingValid_q <= 1'b0;
        end else if (takeBit) begin
            inShift_q <= shiftedWord;
            inCnt_q <= inCnt_q + 5'h01;
            if (wordDone) begin
                pending_q <= shiftedWord;
                pendingValid_q <= 1'b1;
            end
        end
    end

    // staged word replaces the active one only when a conversion ends
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            active_q <= acsp_pkg::CFG_RESET;
            dinSawLow_q <= 1'b0;
            highRun_q <= 2'h0;
            primeCnt_q <= 2'h0;
        end else if (convEnd) begin
            active_q <= nextActive;
            // a low seen in the boundary cycle already counts for the next period
            dinSawLow_q <= ~dinLevel;
            highRun_q <= (dinHighPeriod && !applyDefault) ? highRun_q + 2'h1 : 2'h0;
            if (primeCnt_q != acsp_pkg::PRIME_CONVS) begin
                primeCnt_q <= primeCnt_q + 2'h1;
            end
        end else if (!dinLevel) begin
            dinSawLow_q <= 1'b1;
        end
    end

    // the settings in force are frozen at each conversion start
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            convCfg_q <= acsp_pkg::CFG_RESET;
            chan_q <= 3'h0;
            scanChan_q <= 3'h0;
        end else if (convEnd && cfgChanged) begin
            scanChan_q <= 3'h0;
        end else if (convStart) begin
            convCfg_q <= active_q;
            chan_q <= useChan;
            scanChan_q <= scanOn ? scanNext : 3'h0;
        end
    end

    // result of conversion n is read during acquisition n+1 and after
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sampleCnt_q <= 13'h0000;
            outShift_q <= 30'h00000000;
        end else if (convEnd) begin
            sampleCnt_q <= sampleCnt_q + 13'h0001;
            outShift_q <= {chan_q, sampleCnt_q, echoWord};
        end else if (sclkFall && portOpen) begin
            outShift_q <= {outShift_q[28:0], 1'b0};
        end
    end

    assign link.dataOut = outShift_q[29];
    assign activeConfig = active_q;
    assign configValid = primeCnt_q == acsp_pkg::PRIME_CONVS;
    assign convBusy = convBusy_q;
    assign convDone = convDone_q;
    assign convChannel = chan_q;
    // field decode of the word in force
    assign inputArrangement = active_q[acsp_pkg::ARR_HI:acsp_pkg::ARR_LO];
    assign filterBandwidth = active_q[acsp_pkg::FILT_BIT];
    assign referenceSelect = active_q[acsp_pkg::REF_HI:acsp_pkg::REF_LO];
    assign scanControl = active_q[acsp_pkg::SCAN_HI:acsp_pkg::SCAN_LO];
    assign configEcho = active_q[acsp_pkg::ECHO_BIT];
endmodule

// ===== logic/acsp_host.sv
// Host end: runs spanning accesses on the link, ordered over APB.
// Assumes one APB master on ref_clk; the link clock is made here.
`timescale 1ns/1ps
module acsp_host (
    input wire logic ref_clk,
    input wire logic rst,
    acsp_if.host link,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    typedef enum {H_IDLE, H_BURST1, H_GOHI, H_BURST2, H_WAIT} acsp_hstate_t;

    logic sdoLevel;
    acsp_edge_sync sdoSync (
        .ref_clk(ref_clk),
        .rst(rst),
        .pinIn(link.dataOut),
        .level(sdoLevel),
        .rise(),
        .fall()
    );

    acsp_hstate_t state_q;
    logic [3:0] phase_q;
    logic sclk_q;
    logic go_q;
    logic [4:0] edgeCnt_q;
    logic [7:0] timer_q;
    logic [13:0] tx_q;
    logic [29:0] rx_q;
    logic [13:0] cfgWord_q;
    logic echoEn_q;
    logic preload_q;
    logic abort_q;
    logic [1:0] primeCnt_q;
    logic [15:0] result_q;
    logic [13:0] echo_q;
    logic ack_q;
    logic [31:0] prdata_q;

    wire access = psel & penable;
    wire wrEn = access & ack_q & pwrite;
    wire selCtrl = paddr == acsp_pkg::OFS_CTRL;
    wire selCfg = paddr == acsp_pkg::OFS_CFGW;
    wire selStat = paddr == acsp_pkg::OFS_STAT;
    wire selRes = paddr == acsp_pkg::OFS_RESULT;
    wire selEcho = paddr == acsp_pkg::OFS_ECHO;
    wire mapped = selCtrl | selCfg | selStat | selRes | selEcho;
    wire busy = state_q != H_IDLE;
    wire primed = primeCnt_q == acsp_pkg::PRIME_CONVS;
    wire [31:0] readMux = selCtrl ? {29'h0, preload_q, echoEn_q, 1'b0} :
                          selCfg ? {18'h0, cfgWord_q} :
                          selStat ? {29'h0, abort_q, primed, busy} :
                          selRes ? {16'h0, result_q} :
                          selEcho ? {18'h0, echo_q} : 32'h0;
    wire start = wrEn & selCtrl & pwdata[acsp_pkg::CTRL_START] & ~busy;

    wire inBurst = (state_q == H_BURST1) | (state_q == H_BURST2);
    wire tick = phase_q == acsp_pkg::SCLK_HALF_CYC - 4'h1;
    wire [4:0] totalEdges = echoEn_q ? acsp_pkg::EDGES_ECHO : acsp_pkg::EDGES_PLAIN;
    // first burst stops short so the rest fits before the safe-access time
    wire [4:0] target = (state_q == H_BURST1) ? totalEdges - acsp_pkg::BURST2_EDGES
                                               : totalEdges;
    wire burstDone = tick & sclk_q & (edgeCnt_q == target);
    wire lateStop = (state_q == H_BURST2) && (timer_q >= acsp_pkg::DATA_CYC - 8'h01);
    wire waitDone = timer_q == acsp_pkg::CONV_CYC + acsp_pkg::SYNC_MARGIN;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ack_q <= 1'b0;
            prdata_q <= 32'h0;
            cfgWord_q <= acsp_pkg::CFG_DEFAULT;
            echoEn_q <= 1'b0;
            preload_q <= 1'b0;
        end else begin
            ack_q <= access & ~ack_q;
            if (access && !ack_q) begin
                prdata_q <= readMux;
            end
            if (wrEn && selCfg && !busy) begin
                cfgWord_q <= pwdata[13:0];
            end
            if (wrEn && selCtrl && !busy) begin
                echoEn_q <= pwdata[acsp_pkg::CTRL_ECHO];
                preload_q <= pwdata[acsp_pkg::CTRL_PRELOAD];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            phase_q <= 4'h0;
        end else begin
            phase_q <= (inBurst && !tick) ? phase_q + 4'h1 : 4'h0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= H_IDLE;
            sclk_q <= 1'b0;
            go_q <= 1'b0;
            edgeCnt_q <= 5'h00;
            timer_q <= 8'h00;
            tx_q <= acsp_pkg::CFG_DEFAULT;
            rx_q <= 30'h0;
            abort_q <= 1'b0;
            primeCnt_q <= 2'h0;
            result_q <= 16'h0;
            echo_q <= 14'h0;
        end else begin
            case (state_q)
                H_IDLE: begin
                    if (start) begin
                        // preload keeps data-in high through the whole access
                        tx_q <= preload_q ? acsp_pkg::CFG_DEFAULT : cfgWord_q;
                        edgeCnt_q <= 5'h00;
                        abort_q <= 1'b0;
                        state_q <= H_BURST1;
                    end
                end
                H_BURST1, H_BURST2: begin
                    if (state_q == H_BURST2) begin
                        timer_q <= timer_q + 8'h01;
                    end
                    if (lateStop) begin
                        sclk_q <= 1'b0;
                        abort_q <= 1'b1;
                        state_q <= H_WAIT;
                    end else if (tick && !sclk_q) begin
                        sclk_q <= 1'b1;
                        rx_q <= {rx_q[28:0], sdoLevel};
                        edgeCnt_q <= edgeCnt_q + 5'h01;
                    end else if (tick) begin
                        sclk_q <= 1'b0;
                        tx_q <= {tx_q[12:0], 1'b1};
                        if (burstDone && state_q == H_BURST1) begin
                            timer_q <= 8'h00;
                            state_q <= H_GOHI;
                        end else if (burstDone) begin
                            state_q <= H_WAIT;
                        end
                    end
                end
                H_GOHI: begin
                    // no clocking while the start line is high
                    timer_q <= timer_q + 8'h01;
                    // quiet gap so the far end still shifts on the last fall of burst one
                    if (!go_q && timer_q == acsp_pkg::SYNC_MARGIN - 8'h01) begin
                        go_q <= 1'b1;
                        timer_q <= 8'h00;
                    end else if (go_q && timer_q == acsp_pkg::GO_HIGH_CYC - 8'h01) begin
                        go_q <= 1'b0;
                        state_q <= H_BURST2;
                    end
                end
                H_WAIT: begin
                    timer_q <= timer_q + 8'h01;
                    if (waitDone) begin
                        result_q <= echoEn_q ? rx_q[29:14] : rx_q[15:0];
                        echo_q <= echoEn_q ? rx_q[13:0] : 14'h0;
                        if (!primed) begin
                            primeCnt_q <= primeCnt_q + 2'h1;
                        end
                        state_q <= H_IDLE;
                    end
                end
                default: state_q <= H_IDLE;
            endcase
        end
    end

    assign link.serialClock = sclk_q;
    assign link.conversionStart = go_q;
    assign link.dataIn = tx_q[13];
    assign prdata = prdata_q;
    assign pready = access & ack_q;
    assign pslverr = access & ack_q & ~mapped;
endmodule

// ===== verif/acsp_link_checker.sv
// Concurrent checks on the converter link and the device's active configuration and conversion status outputs.
// Assumes the bench top instantiates it beside the link interface, one clock domain.
`timescale 1ns/1ps
module acsp_link_checker (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic conversionStart,
    input wire logic serialClock,
    input wire logic dataIn,
    input wire logic [13:0] activeConfig,
    input wire logic convBusy,
    input wire logic convDone
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // age starts saturated so that the first access after reset is not taken as late
    logic [7:0] goAge_q;
    logic [7:0] busyLen_q;
    logic goPrev_q;
    always_ff @(posedge ref_clk) begin
        goPrev_q <= conversionStart;
        if (rst) begin
            goAge_q <= 8'hff;
        end else if (conversionStart && !goPrev_q) begin
            goAge_q <= 8'h00;
        end else if (goAge_q != 8'hff) begin
            goAge_q <= goAge_q + 8'h01;
        end
        busyLen_q <= convBusy ? busyLen_q + 8'h01 : 8'h00;
    end

    sequence s_goHigh;
        conversionStart [*8] ##1 conversionStart [*2];
    endsequence
    sequence s_goLow;
        !conversionStart;
    endsequence

    property p_go_pulse;
        $rose(conversionStart) |-> s_goHigh ##1 s_goLow;
    endproperty
    a_go_pulse: assert property (p_go_pulse)
        else $error("conversion start pulse length wrong");

    property p_quiet_go;
        conversionStart && $past(conversionStart) |-> $stable(serialClock) && !serialClock;
    endproperty
    a_quiet_go: assert property (p_quiet_go)
        else $error("serial clock moved while conversion start high");

    property p_sclk_high;
        $rose(serialClock) |-> serialClock [*8] ##1 !serialClock;
    endproperty
    a_sclk_high: assert property (p_sclk_high)
        else $error("serial clock high phase not eight cycles");

    property p_din_hold;
        serialClock && $past(serialClock) |-> $stable(dataIn);
    endproperty
    a_din_hold: assert property (p_din_hold)
        else $error("data in changed while serial clock high");

    property p_safe;
        $rose(serialClock) |-> (goAge_q < 8'h78) || (goAge_q > 8'haa);
    endproperty
    a_safe: assert property (p_safe)
        else $error("serial clock edge after safe access time");

    property p_busy_after;
        $rose(conversionStart) |-> ##[2:8] $rose(convBusy);
    endproperty
    a_busy_after: assert property (p_busy_after)
        else $error("conversion did not start after start pulse");

    property p_conv_len;
        $fell(convBusy) |-> busyLen_q inside {[8'h9b:8'ha5]};
    endproperty
    a_conv_len: assert property (p_conv_len)
        else $error("conversion length out of range");

    property p_cfg_at_end;
        $changed(activeConfig) |-> ##[0:2] convDone;
    endproperty
    a_cfg_at_end: assert property (p_cfg_at_end)
        else $error("configuration changed away from conversion end");

    property p_done_pulse;
        convDone |=> !convDone;
    endproperty
    a_done_pulse: assert property (p_done_pulse)
        else $error("conversion done longer than one cycle");
endmodule

// ===== verif/tb_acsp.sv
// Self-checking bench: host and device joined over the link, host driven over APB.
// Assumes the package offsets and the one-wait-state APB answer of the host.
`timescale 1ns/1ps
module tb_acsp;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] rdata;
    logic perr;
    logic [13:0] activeConfig;
    logic configValid;
    logic convBusy;
    logic convDone;
    logic [2:0] convChannel;
    logic [2:0] inputArrangement;
    logic filterBandwidth;
    logic [2:0] referenceSelect;
    logic [1:0] scanControl;
    logic configEcho;
    int failures = 0;
    int n_checks = 0;

    acsp_if link_if();
    acsp_device acsp_device_i (.ref_clk(ref_clk), .rst(rst), .link(link_if.device),
        .activeConfig(activeConfig), .configValid(configValid), .convBusy(convBusy),
        .convDone(convDone), .convChannel(convChannel), .inputArrangement(inputArrangement),
        .filterBandwidth(filterBandwidth), .referenceSelect(referenceSelect),
        .scanControl(scanControl), .configEcho(configEcho));
    acsp_host acsp_host_i (.ref_clk(ref_clk), .rst(rst), .link(link_if.host), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    acsp_link_checker acsp_link_checker_i (.ref_clk(ref_clk), .rst(rst),
        .conversionStart(link_if.conversionStart), .serialClock(link_if.serialClock),
        .dataIn(link_if.dataIn), .activeConfig(activeConfig), .convBusy(convBusy),
        .convDone(convDone));

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic results();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // the answer is taken at the rising edge that ends the access; only the watchdog ends a wait
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        logic rdy;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            rdy = pready;
            rdata = prdata;
            perr = pslverr;
        end while (rdy !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic waitDone();
        int n;
        n = 0;
        while (convDone !== 1'b1 && n < 3000) begin
            @(posedge ref_clk);
            n++;
        end
        do begin
            apb(1'b0, acsp_pkg::OFS_STAT, 32'h0);
            n++;
        end while (rdata[0] !== 1'b0 && n < 3500);
        if (n >= 3500) begin
            failures++;
        end
    endtask

    task automatic access(input logic [13:0] cfg, input logic [31:0] ctrl);
        apb(1'b1, acsp_pkg::OFS_CFGW, {18'h0, cfg});
        apb(1'b1, acsp_pkg::OFS_CTRL, ctrl);
        waitDone();
    endtask

    task automatic t_reset();
        chk(32'(activeConfig), 32'h0, "config after reset");
        chk(32'(configValid), 32'h0, "valid after reset");
        apb(1'b0, acsp_pkg::OFS_CFGW, 32'h0);
        chk(rdata, 32'h3fff, "staged word reset");
        apb(1'b0, 12'h014, 32'h0);
        chk({31'h0, perr}, 32'h1, "unmapped error");
        $display("test reset done");
    endtask

    task automatic t_default();
        access(14'h3fff, 32'h1);
        access(14'h3fff, 32'h1);
        chk(32'(configValid), 32'h1, "valid after two");
        chk(32'(activeConfig), 32'h3fff, "all ones word");
        chk({inputArrangement, filterBandwidth, referenceSelect, scanControl, configEcho},
            32'h3ff, "default fields");
        apb(1'b0, acsp_pkg::OFS_STAT, 32'h0);
        chk(rdata, 32'h2, "primed, idle, no abort");
        $display("test default done");
    endtask

    task automatic t_pipeline();
        apb(1'b1, acsp_pkg::OFS_CFGW, 32'h2e91);
        apb(1'b1, acsp_pkg::OFS_CTRL, 32'h1);
        chk(32'(activeConfig), 32'h3fff, "old word during access");
        apb(1'b1, acsp_pkg::OFS_CFGW, 32'h1555);
        waitDone();
        chk(32'(activeConfig), 32'h2e91, "new word at end");
        apb(1'b0, acsp_pkg::OFS_CFGW, 32'h0);
        chk(rdata, 32'h2e91, "write while busy");
        access(14'h2e91, 32'h1);
        access(14'h2e91, 32'h1);
        chk(32'(convChannel), 32'h5, "converted channel");
        apb(1'b0, acsp_pkg::OFS_RESULT, 32'h0);
        chk(rdata, 32'h0000a003, "channel and count of previous");
        access(14'h0123, 32'h1);
        chk(32'(activeConfig), 32'h2e91, "update bit clear");
        $display("test pipeline done");
    endtask

    task automatic t_fields();
        logic [13:0] w;
        logic [13:0] cfgNow;
        logic [13:0] cfgOld;
        cfgNow = 14'h2e91;
        cfgOld = 14'h2e91;
        for (int i = 0; i < 8; i++) begin
            w = {1'b1, 3'(i), 3'(7 - i), i[0], 3'(i ^ 5), 2'(i), ~i[0]};
            access(w, {30'h0, i[0], 1'b1});
            chk(32'(activeConfig), 32'(w), "word applied");
            chk(32'(inputArrangement), 32'(w[12:10]), "arrangement");
            chk({filterBandwidth, referenceSelect, scanControl, configEcho},
                32'(w[6:0]), "low fields");
            // the echo read now belongs to the word written two accesses back
            if (i[0]) begin
                apb(1'b0, acsp_pkg::OFS_ECHO, 32'h0);
                chk(rdata, cfgOld[0] ? 32'h0 : 32'(cfgOld), "echo word");
            end
            cfgOld = cfgNow;
            cfgNow = w;
        end
        $display("test fields done");
    endtask

    initial begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        t_reset();
        t_default();
        t_pipeline();
        t_fields();
        results();
    end

    // the run needs about 6000 cycles; ten times that means a hang
    initial begin
        repeat (60000) @(posedge ref_clk);
        failures++;
        results();
    end
endmodule
